// [hdl/cgi_pkg.sv]
// Package: constants for the configuration init pulse block
package cgi_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MIN_RESET_WIDTH_NS = 100;
    localparam int TRISTATE_PULSE_WIDTH_FUNC_NS = 100;
    localparam int TRISTATE_PULSE_WIDTH_TIMING_NS = 0;
    // Least widths round up to whole cycles, never below one
    localparam int MIN_RESET_WIDTH_CYC =
        ((MIN_RESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
        (MIN_RESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRISTATE_PULSE_WIDTH_CYC =
        ((TRISTATE_PULSE_WIDTH_FUNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
        (TRISTATE_PULSE_WIDTH_FUNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic RESET_ACTIVE_HIGH = 1'b1;
endpackage

// [hdl/cgi_pulse_gen.sv]
// One-shot pulse generator, fires once per trigger
`timescale 1ns/1ns
module cgi_pulse_gen #(
    parameter logic [7:0] WIDTH = 8'h03
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic trig,
    output logic pulse
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic pulse_ff;
    logic nxt_pulse;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_pulse = pulse_ff;
        if (trig) begin
            nxt_cnt = WIDTH;
            nxt_pulse = 1'b1;
        end else if (cnt_ff > 8'h01) begin
            nxt_cnt = cnt_ff - 8'h01;
        end else begin
            nxt_cnt = 8'h00;
            nxt_pulse = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= cgi_pkg::CNT_RST;
            pulse_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse = pulse_ff;
endmodule // cgi_pulse_gen

// [hdl/cgi_top.sv]
// Top: configuration and power-up global reset and tristate pulses
// Behaviour
// - Global set/reset pulses once at configuration end and once after power-up.
// - Each register goes to its own initial value while reset is active.
// - Outputs are high impedance while the tristate net is active.
// - Reset active high by default; low variant drops the tristate net.
// - Tristate pulse generator is separate from the reset generator.
// - Reset pulse covers at least the minimum reset width, a parameter.
// - Tristate pulse covers at least the tristate width, a parameter.
// - Self-timed reset generator gives one high pulse per trigger, default 3 cycles (120 ns).
// - The user registers share one asynchronous input from the reset net.
// - Self-timed tristate generator gives one high pulse per trigger, default 3 cycles (120 ns).
`timescale 1ns/1ns
module cgi_top #(
    parameter logic ACTIVE_HIGH = cgi_pkg::RESET_ACTIVE_HIGH,
    parameter logic USE_PORT_BUFFER = 1'b0,
    parameter logic [7:0] RESET_WIDTH_CYC = 8'(cgi_pkg::MIN_RESET_WIDTH_CYC),
    parameter logic [7:0] TRISTATE_WIDTH_CYC = 8'(cgi_pkg::TRISTATE_PULSE_WIDTH_CYC)
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic config_done,
    input wire logic tb_set_reset,
    input wire logic tb_tristate,
    input wire logic [7:0] user_d,
    input wire logic [7:0] user_init,
    input wire logic [7:0] user_oe,
    output logic global_set_reset_net,
    output logic global_output_tristate_net,
    output logic [7:0] user_q,
    output logic [7:0] pad_o,
    output logic [7:0] pad_oe
);
    typedef enum logic [1:0] {ST_POWERUP, ST_WAIT_CFG, ST_RUN} cgi_state_e;
    cgi_state_e state_ff;
    cgi_state_e nxt_state;
    logic fire;
    logic rst_pulse;
    logic ts_pulse;
    logic gsr_act;
    logic cfg_d_ff;
    logic nxt_cfg_d;
    logic [7:0] user_q_ff;
    logic [7:0] nxt_user_q;
    logic init_hold_ff;
    logic nxt_init_hold;

    // Fire at power-up, then once more at configuration end
    // Rise detect on config_done, so a level left high fires only once
    always_comb begin
        nxt_state = state_ff;
        nxt_cfg_d = config_done;
        fire = 1'b0;
        unique case (state_ff)
            ST_POWERUP: begin
                fire = 1'b1;
                nxt_state = ST_WAIT_CFG;
            end
            ST_WAIT_CFG: begin
                if (config_done && !cfg_d_ff) begin
                    fire = 1'b1;
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_POWERUP;
            cfg_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cfg_d_ff <= nxt_cfg_d;
        end
    end

    // Two generators so widths can differ
    cgi_pulse_gen #(.WIDTH(RESET_WIDTH_CYC)) u_reset_on_config_pulse_gen (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .trig(fire),
        .pulse(rst_pulse)
    );
    cgi_pulse_gen #(.WIDTH(TRISTATE_WIDTH_CYC)) u_tristate_on_config_pulse_gen (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .trig(fire),
        .pulse(ts_pulse)
    );

    // Port buffers hand the nets to the testbench; gone in real silicon
    assign gsr_act = USE_PORT_BUFFER ? tb_set_reset : rst_pulse;
    assign global_set_reset_net = ACTIVE_HIGH ? gsr_act : !gsr_act;
    // Low variant has no tristate net
    assign global_output_tristate_net = ACTIVE_HIGH &&
        (USE_PORT_BUFFER ? tb_tristate : ts_pulse);

    // Demo user registers: one common async input from the global net
    always_comb begin
        nxt_user_q = user_d;
        nxt_init_hold = 1'b0;
    end

    always_ff @(posedge sys_clk or posedge gsr_act) begin
        if (gsr_act) begin
            user_q_ff <= 8'h00;
            init_hold_ff <= 1'b1;
        end else begin
            user_q_ff <= nxt_user_q;
            init_hold_ff <= nxt_init_hold;
        end
    end

    // Async branch may load constants only, so the initial value is muxed in
    // and held until the first clock after the net falls
    assign user_q = (gsr_act || init_hold_ff) ? user_init : user_q_ff;
    assign pad_o = user_q;
    assign pad_oe = global_output_tristate_net ? 8'h00 : user_oe;

    // Counts of 3 below follow the default width parameters
    property p_powerup_rst;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ST_POWERUP) |=> rst_pulse [*3];
    endproperty
    a_powerup_rst: assert property (p_powerup_rst)
        else $error("power-up reset pulse missing");

    property p_powerup_ts;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ST_POWERUP) |=> ts_pulse [*3];
    endproperty
    a_powerup_ts: assert property (p_powerup_ts)
        else $error("power-up tristate pulse missing");

    // A retrigger inside the pulse may legally stretch it
    property p_reset_ends;
        @(posedge sys_clk) disable iff (sys_rst)
        ($rose(rst_pulse) && !fire) ##1 (!fire [*2]) |=> !rst_pulse;
    endproperty
    a_reset_ends: assert property (p_reset_ends)
        else $error("reset pulse width wrong");

    property p_ts_ends;
        @(posedge sys_clk) disable iff (sys_rst)
        ($rose(ts_pulse) && !fire) ##1 (!fire [*2]) |=> !ts_pulse;
    endproperty
    a_ts_ends: assert property (p_ts_ends)
        else $error("tristate pulse width wrong");

    property p_cfg_fire;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ST_WAIT_CFG && config_done && !cfg_d_ff) |=> rst_pulse && ts_pulse;
    endproperty
    a_cfg_fire: assert property (p_cfg_fire)
        else $error("config-end pulse missing");

    property p_cfg_rst_width;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ST_WAIT_CFG && config_done && !cfg_d_ff) |=> rst_pulse [*3];
    endproperty
    a_cfg_rst_width: assert property (p_cfg_rst_width)
        else $error("config-end reset pulse too short");

    property p_cfg_ts_width;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ST_WAIT_CFG && config_done && !cfg_d_ff) |=> ts_pulse [*3];
    endproperty
    a_cfg_ts_width: assert property (p_cfg_ts_width)
        else $error("config-end tristate pulse too short");

    property p_ts_hiz;
        @(posedge sys_clk) disable iff (sys_rst)
        global_output_tristate_net |-> pad_oe == 8'h00;
    endproperty
    a_ts_hiz: assert property (p_ts_hiz)
        else $error("output driven during tristate");

    property p_reg_init;
        @(posedge sys_clk) disable iff (sys_rst)
        gsr_act |-> user_q == user_init;
    endproperty
    a_reg_init: assert property (p_reg_init)
        else $error("register not at initial value");

    // Start-up value must survive until the first clock after release
    property p_hold_init;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(gsr_act) |-> user_q == user_init;
    endproperty
    a_hold_init: assert property (p_hold_init)
        else $error("initial value lost at reset release");

    property p_no_repeat;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ST_RUN) |-> !fire;
    endproperty
    a_no_repeat: assert property (p_no_repeat)
        else $error("generator fired again");

    property p_run_stays;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_ff == ST_RUN) |=> (state_ff == ST_RUN);
    endproperty
    a_run_stays: assert property (p_run_stays)
        else $error("left run state without reset");

    property p_polarity;
        @(posedge sys_clk) disable iff (sys_rst)
        global_set_reset_net == (ACTIVE_HIGH ? gsr_act : !gsr_act);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("reset polarity wrong");

    // Main scenarios
    c_cfg: cover property (@(posedge sys_clk) state_ff == ST_WAIT_CFG ##1 state_ff == ST_RUN);
    c_rst: cover property (@(posedge sys_clk) $fell(rst_pulse));
    c_ts: cover property (@(posedge sys_clk) $fell(ts_pulse));
    c_refused: cover property (@(posedge sys_clk)
        state_ff == ST_RUN && config_done && !cfg_d_ff);
endmodule // cgi_top

// [test/cgi_user_reg_model.sv]
// Partner model: one user register on the global set/reset net
`timescale 1ns/1ns
module cgi_user_reg_model (
    input wire logic sys_clk,
    input wire logic rst_net,
    input wire logic [7:0] d,
    input wire logic [7:0] init,
    output logic [7:0] q
);
    // Async load, so start-up state matches at every stage
    always_ff @(posedge sys_clk or posedge rst_net) begin
        if (rst_net) begin
            q <= init;
        end else begin
            q <= d;
        end
    end
endmodule // cgi_user_reg_model

// [test/tb_config_global_init_pulses.sv]
// Testbench for the configuration init pulse block
`timescale 1ns/1ns
module tb_config_global_init_pulses;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic config_done = 1'b0;
    logic tb_set_reset = 1'b0;
    logic tb_tristate = 1'b0;
    logic [7:0] user_d = 8'h00;
    logic [7:0] user_init = 8'h5a;
    logic [7:0] user_oe = 8'h00;
    logic global_set_reset_net, global_output_tristate_net, gsr_lo, gts_lo, gsr_pb, gts_pb;
    logic [7:0] user_q, pad_o, pad_oe, model_q;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 32'hb84a;
    int hi_rst, hi_ts;
    logic [7:0] w_rst, w_ts;
    always #20 sys_clk = ~sys_clk;
    cgi_top #(
        .RESET_WIDTH_CYC(8'(cgi_pkg::MIN_RESET_WIDTH_CYC)),
        .TRISTATE_WIDTH_CYC(8'(cgi_pkg::TRISTATE_PULSE_WIDTH_CYC))
    ) u_dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .config_done(config_done),
        .tb_set_reset(tb_set_reset),
        .tb_tristate(tb_tristate),
        .user_d(user_d),
        .user_init(user_init),
        .user_oe(user_oe),
        .global_set_reset_net(global_set_reset_net),
        .global_output_tristate_net(global_output_tristate_net),
        .user_q(user_q),
        .pad_o(pad_o),
        .pad_oe(pad_oe)
    );
    cgi_top #(.ACTIVE_HIGH(1'b0)) u_low (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .config_done(config_done),
        .tb_set_reset(tb_set_reset),
        .tb_tristate(tb_tristate),
        .user_d(user_d),
        .user_init(user_init),
        .user_oe(user_oe),
        .global_set_reset_net(gsr_lo),
        .global_output_tristate_net(gts_lo),
        .user_q(),
        .pad_o(),
        .pad_oe()
    );
    cgi_top #(.USE_PORT_BUFFER(1'b1)) u_pb (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .config_done(config_done),
        .tb_set_reset(tb_set_reset),
        .tb_tristate(tb_tristate),
        .user_d(user_d),
        .user_init(user_init),
        .user_oe(user_oe),
        .global_set_reset_net(gsr_pb),
        .global_output_tristate_net(gts_pb),
        .user_q(),
        .pad_o(),
        .pad_oe()
    );
    cgi_user_reg_model u_model (.sys_clk(sys_clk), .rst_net(global_set_reset_net),
        .d(user_d), .init(user_init), .q(model_q));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Least width in whole cycles, never below one
    function automatic logic [7:0] exp_cycles(input int ns);
        int n;
        n = (ns + cgi_pkg::CLK_PERIOD_NS - 1) / cgi_pkg::CLK_PERIOD_NS;
        return (n < 1) ? 8'h01 : 8'(n);
    endfunction
    function automatic logic [7:0] exp_oe(input logic ts, input logic [7:0] oe);
        return ts ? 8'h00 : oe;
    endfunction
    // Checks at the falling edge, then new random inputs
    task automatic cycles(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            hi_rst += int'(global_set_reset_net);
            hi_ts += int'(global_output_tristate_net);
            chk(user_q, model_q);
            chk(pad_oe, exp_oe(global_output_tristate_net, user_oe));
            chk(pad_o, user_q);
            chk({7'h00, gsr_lo}, {7'h00, ~global_set_reset_net});
            chk({7'h00, gts_lo}, 8'h00);
            chk({6'h00, gsr_pb, gts_pb}, {6'h00, tb_set_reset, tb_tristate});
            user_d = 8'($random(seed));
            user_oe = 8'($random(seed));
            tb_set_reset = 1'($random(seed));
            tb_tristate = 1'($random(seed));
        end
    endtask
    task automatic window(input logic [7:0] exp_r, input logic [7:0] exp_t);
        hi_rst = 0;
        hi_ts = 0;
        cycles(8);
        chk(8'(hi_rst), exp_r);
        chk(8'(hi_ts), exp_t);
    endtask
    initial begin
        w_rst = exp_cycles(cgi_pkg::MIN_RESET_WIDTH_NS);
        w_ts = exp_cycles(cgi_pkg::TRISTATE_PULSE_WIDTH_FUNC_NS);
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        window(w_rst, w_ts);
        config_done = 1'b1;
        window(w_rst, w_ts);
        config_done = 1'b0;
        cycles(2);
        // A second rise must be ignored
        config_done = 1'b1;
        window(8'h00, 8'h00);
        cycles(20);
        // Power cycle mid-run: only the power-up pulse comes back
        sys_rst = 1'b1;
        cycles(2);
        sys_rst = 1'b0;
        window(w_rst, w_ts);
        cycles(20);
        give_verdict();
    end
    // Run needs about 83 cycles; generous margin
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
endmodule // tb_config_global_init_pulses
